// >>> hw/tmr8_top.sv
// 8-bit timer/counter core with two compare units and flags
// How it works
// [RULE1] count and compare registers: eight bits, read/write
// [RULE2] each tick clears, increments or decrements per mode
// [RULE3] step exactly one; clear zeroes all bits
// [RULE4] tick from prescaler tap or external pin
// [RULE5] clock select zero stops the counter
// [RULE6] count readable and writable at any time
// [RULE7] processor write beats clear and count
// [RULE8] bottom indication at count 0x00
// [RULE9] maximum recognised at count 0xff
// [RULE10] top is 0xff or compare A
// [RULE11] three mode bits select the sequence
// [RULE12] overflow flag set per mode, may interrupt
// [RULE13] both compare values checked every cycle
// [RULE14] match sets its flag, may interrupt
// [RULE15] two compare units, double buffered
// [RULE16] compare results drive both compare pins
// [RULE17] three flags, each with own mask bit
// [RULE18] match flag set on following tick
// [RULE19] writing one clears a pending flag
// [RULE20] normal mode wraps, overflow when reaching zero
// [RULE21] external pin synchronised, one tick per edge
module tmr8_top
   import tmr8_pkg::*;
#(
   parameter int TAPS = N_TAPS
) (
   // clock and reset
   input wire logic MCLK,
   input wire logic RST_N,
   // count sources
   input wire logic EXT_COUNT_INPUT,
   input wire logic [TAPS-1:0] PRESCALE_TAP,
   // configuration
   input wire logic [2:0] CLOCK_SELECT_FIELD,
   input wire logic WAVE_MODE_BIT0,
   input wire logic WAVE_MODE_BIT1,
   input wire logic WAVE_MODE_BIT2,
   input wire logic [1:0] OUTPUT_MODE_A,
   input wire logic [1:0] OUTPUT_MODE_B,
   input wire logic FORCE_MATCH_A,
   input wire logic FORCE_MATCH_B,
   // processor writes
   input wire logic COUNT_WRITE,
   input wire logic [CNT_W-1:0] COUNT_WDATA,
   input wire logic COMPARE_A_WRITE,
   input wire logic [CNT_W-1:0] COMPARE_A_WDATA,
   input wire logic COMPARE_B_WRITE,
   input wire logic [CNT_W-1:0] COMPARE_B_WDATA,
   // flag control
   input wire logic [N_FLAGS-1:0] MASK_REGISTER,
   input wire logic [N_FLAGS-1:0] FLAG_CLEAR,
   // readback
   output logic [CNT_W-1:0] COUNT_VALUE,
   output logic [CNT_W-1:0] COMPARE_VALUE_A,
   output logic [CNT_W-1:0] COMPARE_VALUE_B,
   output logic [N_FLAGS-1:0] FLAG_REGISTER,
   // interrupt requests
   output logic [N_FLAGS-1:0] INT_REQUEST,
   // waveform pins
   output logic COMPARE_PIN_A,
   output logic COMPARE_PIN_B
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic down;
      logic blk;
      logic [N_FLAGS-1:0] flags;
      logic [N_FLAGS-1:0] irq;
      logic [N_UNITS-1:0] oc;
      logic [N_UNITS-1:0] pin;
   } tmr8_top_s;

   tmr8_top_s st;
   tmr8_top_s next_st;

   tmr8_if tif ();

   logic tick;
   logic [2:0] wgm;
   tmr8_kind_e kind;
   logic use_ocr_top;
   logic pwm;
   logic [CNT_W-1:0] top_val;
   logic [CNT_W-1:0] ocr_a;
   logic at_top;
   logic at_bottom;
   logic at_max;
   logic ovf_hit;
   logic [N_UNITS-1:0] match;
   logic [N_UNITS-1:0] force_m;
   logic [N_UNITS-1:0] event_m;
   logic [1:0] com [N_UNITS];
   logic [N_FLAGS-1:0] flag_set;
   logic wrap;
   logic oc_n;
   logic drive;

   // tick source
   tmr8_tick #(
      .TAPS(TAPS)
   ) u_tick (
      .clk(MCLK),
      .rst_n(RST_N),
      .ext_pin(EXT_COUNT_INPUT),
      .taps(PRESCALE_TAP),
      .sel(CLOCK_SELECT_FIELD),
      .tick(tick)
   );

   // compare unit a, also supplies the variable top
   tmr8_cmp u_cmp_a (
      .clk(MCLK),
      .rst_n(RST_N),
      .tb(tif.unit),
      .wr(COMPARE_A_WRITE),
      .wdata(COMPARE_A_WDATA),
      .buf_val(COMPARE_VALUE_A),
      .ocr_val(ocr_a),
      .match(match[0])
   );

   // compare unit b
   tmr8_cmp u_cmp_b (
      .clk(MCLK),
      .rst_n(RST_N),
      .tb(tif.unit),
      .wr(COMPARE_B_WRITE),
      .wdata(COMPARE_B_WDATA),
      .buf_val(COMPARE_VALUE_B),
      .ocr_val(),
      .match(match[1])
   );

   // mode decode
   always_comb begin
      wgm = {WAVE_MODE_BIT2, WAVE_MODE_BIT1, WAVE_MODE_BIT0}; // [RULE11]
      case (wgm)
         WGM_PHASE_MAX: begin
            kind = TMR8_PHASE;
            use_ocr_top = 1'b0;
         end
         WGM_CTC: begin
            kind = TMR8_CTC;
            use_ocr_top = 1'b1;
         end
         WGM_FAST_MAX: begin
            kind = TMR8_FAST;
            use_ocr_top = 1'b0;
         end
         WGM_PHASE_OCR: begin
            kind = TMR8_PHASE;
            use_ocr_top = 1'b1;
         end
         WGM_FAST_OCR: begin
            kind = TMR8_FAST;
            use_ocr_top = 1'b1;
         end
         default: begin
            kind = TMR8_NORMAL;
            use_ocr_top = 1'b0;
         end
      endcase
   end

   assign pwm = (kind == TMR8_FAST) || (kind == TMR8_PHASE);
   assign top_val = use_ocr_top ? ocr_a : CNT_MAX; // [RULE10]
   assign at_top = (st.cnt == top_val); // [RULE10]
   assign at_bottom = (st.cnt == CNT_BOTTOM); // [RULE8]
   assign at_max = (st.cnt == CNT_MAX); // [RULE9]

   // counter state to the compare units
   assign tif.cnt = st.cnt;
   assign tif.tick = tick;
   assign tif.blk = st.blk;
   assign tif.at_top = at_top;
   assign tif.kind = kind;

   assign force_m = {FORCE_MATCH_B, FORCE_MATCH_A};
   assign com[0] = OUTPUT_MODE_A;
   assign com[1] = OUTPUT_MODE_B;

   always_comb begin
      next_st = st;
      ovf_hit = 1'b0;
      wrap = 1'b0;
      oc_n = 1'b0;
      drive = 1'b0;
      event_m = '0;

      // counting, only on a tick
      if (tick) begin // [RULE5]
         next_st.blk = 1'b0;
         case (kind) // [RULE2]
            TMR8_CTC: begin
               if (at_top) begin
                  next_st.cnt = CNT_BOTTOM; // [RULE3]
               end else begin
                  next_st.cnt = st.cnt + CNT_STEP; // [RULE3]
               end
               ovf_hit = at_max; // [RULE12]
               next_st.down = 1'b0;
            end
            TMR8_FAST: begin
               wrap = at_top;
               if (at_top) begin
                  next_st.cnt = CNT_BOTTOM; // [RULE3]
               end else begin
                  next_st.cnt = st.cnt + CNT_STEP;
               end
               ovf_hit = at_top; // [RULE12]
               next_st.down = 1'b0;
            end
            TMR8_PHASE: begin
               if (at_top && at_bottom) begin
                  next_st.cnt = CNT_BOTTOM;
               end else if (st.down && at_bottom) begin
                  next_st.down = 1'b0;
                  next_st.cnt = st.cnt + CNT_STEP;
               end else if (!st.down && at_top) begin
                  next_st.down = 1'b1;
                  next_st.cnt = st.cnt - CNT_STEP; // [RULE3]
               end else if (st.down) begin
                  next_st.cnt = st.cnt - CNT_STEP;
               end else begin
                  next_st.cnt = st.cnt + CNT_STEP;
               end
               ovf_hit = at_bottom; // [RULE12]
            end
            default: begin
               next_st.cnt = st.cnt + CNT_STEP; // [RULE20]
               ovf_hit = at_max; // [RULE20]
               next_st.down = 1'b0;
            end
         endcase
      end

      // processor write wins, and blocks the next tick's matches
      if (COUNT_WRITE) begin // [RULE6]
         next_st.cnt = COUNT_WDATA; // [RULE7]
         next_st.blk = 1'b1;
      end

      // flags: a set in the clearing cycle survives
      flag_set = '0;
      flag_set[FLG_OVF] = ovf_hit; // [RULE12]
      flag_set[FLG_MA] = match[0]; // [RULE14]
      flag_set[FLG_MB] = match[1]; // [RULE14]
      next_st.flags = (st.flags & ~FLAG_CLEAR) | flag_set; // [RULE19]
      next_st.irq = st.flags & MASK_REGISTER; // [RULE17]

      // waveform per unit
      for (int i = 0; i < N_UNITS; i++) begin
         oc_n = st.oc[i];
         case (kind)
            TMR8_FAST: begin
               if (wrap) begin
                  oc_n = (com[i] == COM_CLEAR);
               end
               if (match[i]) begin
                  if (com[i] == COM_CLEAR) begin
                     oc_n = 1'b0;
                  end else if (com[i] == COM_SET) begin
                     oc_n = 1'b1;
                  end else if (com[i] == COM_TOGGLE && i == 0 && wgm[2]) begin
                     oc_n = ~st.oc[i];
                  end
               end
            end
            TMR8_PHASE: begin
               if (match[i]) begin
                  if (com[i] == COM_CLEAR) begin
                     oc_n = st.down;
                  end else if (com[i] == COM_SET) begin
                     oc_n = ~st.down;
                  end else if (com[i] == COM_TOGGLE && i == 0 && wgm[2]) begin
                     oc_n = ~st.oc[i];
                  end
               end
            end
            default: begin
               event_m[i] = match[i] | force_m[i];
               if (event_m[i]) begin
                  case (com[i])
                     COM_TOGGLE: oc_n = ~st.oc[i];
                     COM_CLEAR: oc_n = 1'b0;
                     COM_SET: oc_n = 1'b1;
                     default: oc_n = st.oc[i];
                  endcase
               end
            end
         endcase
         drive = (com[i] != COM_OFF) &&
            !(pwm && com[i] == COM_TOGGLE && !(i == 0 && wgm[2]));
         next_st.oc[i] = oc_n;
         next_st.pin[i] = drive & oc_n; // [RULE16]
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         st.cnt <= CNT_RESET;
         st.down <= 1'b0;
         st.blk <= 1'b0;
         st.flags <= FLAG_RESET;
         st.irq <= FLAG_RESET;
         st.oc <= {N_UNITS{OC_RESET}};
         st.pin <= {N_UNITS{OC_RESET}};
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state
   assign COUNT_VALUE = st.cnt; // [RULE6]
   assign FLAG_REGISTER = st.flags; // [RULE17]
   assign INT_REQUEST = st.irq;
   assign COMPARE_PIN_A = st.pin[0];
   assign COMPARE_PIN_B = st.pin[1];
endmodule // tmr8_top

// >>> hw/tmr8_pkg.sv
// shared constants and types of the 8-bit timer/counter
package tmr8_pkg;
   localparam int CNT_W = 8;
   localparam logic [7:0] CNT_BOTTOM = 8'h00;
   localparam logic [7:0] CNT_MAX = 8'hff;
   localparam logic [7:0] CNT_STEP = 8'h01;
   localparam logic [7:0] CNT_RESET = 8'h00;
   localparam logic [7:0] OCR_RESET = 8'h00;
   localparam logic OC_RESET = 1'b0;
   // waveform mode codes, wave_mode_bit2..0
   localparam logic [2:0] WGM_NORMAL = 3'h0;
   localparam logic [2:0] WGM_PHASE_MAX = 3'h1;
   localparam logic [2:0] WGM_CTC = 3'h2;
   localparam logic [2:0] WGM_FAST_MAX = 3'h3;
   localparam logic [2:0] WGM_PHASE_OCR = 3'h5;
   localparam logic [2:0] WGM_FAST_OCR = 3'h7;
   // clock_select_field codes
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [2:0] CS_SYS = 3'h1;
   localparam logic [2:0] CS_TAP_BASE = 3'h2;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;
   localparam int N_TAPS = 4;
   // compare output action codes
   localparam logic [1:0] COM_OFF = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam logic [1:0] COM_CLEAR = 2'h2;
   localparam logic [1:0] COM_SET = 2'h3;
   // flag_register bit positions
   localparam int N_FLAGS = 3;
   localparam int FLG_OVF = 0;
   localparam int FLG_MA = 1;
   localparam int FLG_MB = 2;
   localparam logic [2:0] FLAG_RESET = 3'h0;
   localparam int N_UNITS = 2;
   typedef enum logic [1:0] {TMR8_NORMAL, TMR8_CTC, TMR8_FAST, TMR8_PHASE} tmr8_kind_e;
endpackage

// >>> hw/tmr8_if.sv
// counter state shared between the counter core and the compare units
interface tmr8_if;
   import tmr8_pkg::*;
   logic [CNT_W-1:0] cnt;
   logic tick;
   logic blk;
   logic at_top;
   tmr8_kind_e kind;
   modport core (output cnt, output tick, output blk, output at_top, output kind);
   modport unit (input cnt, input tick, input blk, input at_top, input kind);
endinterface

// >>> hw/tmr8_tick.sv
// timer tick source selection and external pin edge detection
module tmr8_tick
   import tmr8_pkg::*;
#(
   parameter int TAPS = N_TAPS
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // sources
   input wire logic ext_pin,
   input wire logic [TAPS-1:0] taps,
   input wire logic [2:0] sel,
   // count enable
   output logic tick
);
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic prev;
   } tmr8_tick_s;

   tmr8_tick_s st;
   tmr8_tick_s next_st;
   logic [2:0] tap_idx;

   always_comb begin
      next_st.sync1 = ext_pin; // [RULE21]
      next_st.sync2 = st.sync1;
      next_st.prev = st.sync2;
      tap_idx = sel - CS_TAP_BASE;
      case (sel) // [RULE4]
         CS_STOP: tick = 1'b0; // [RULE5]
         CS_SYS: tick = 1'b1;
         CS_EXT_FALL: tick = st.prev & ~st.sync2; // [RULE21]
         CS_EXT_RISE: tick = st.sync2 & ~st.prev; // [RULE21]
         default: tick = taps[tap_idx[1:0]];
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule // tmr8_tick

// >>> hw/tmr8_cmp.sv
// one compare unit: double-buffered compare value and match detection
module tmr8_cmp
   import tmr8_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // counter state
   tmr8_if.unit tb,
   // processor write
   input wire logic wr,
   input wire logic [CNT_W-1:0] wdata,
   // results
   output logic [CNT_W-1:0] buf_val,
   output logic [CNT_W-1:0] ocr_val,
   output logic match
);
   typedef struct packed {
      logic [CNT_W-1:0] buffer;
      logic [CNT_W-1:0] ocr;
   } tmr8_cmp_s;

   tmr8_cmp_s st;
   tmr8_cmp_s next_st;
   logic pwm;

   always_comb begin
      next_st = st;
      pwm = (tb.kind == TMR8_FAST) || (tb.kind == TMR8_PHASE);
      // pwm modes load the active value at top only
      if (pwm && tb.tick && tb.at_top) begin
         next_st.ocr = st.buffer; // [RULE15]
      end
      if (wr) begin
         next_st.buffer = wdata; // [RULE1]
         if (!pwm) begin
            next_st.ocr = wdata;
         end
      end
      // equality checked every cycle, flagged on the next tick
      match = tb.tick && !tb.blk && (tb.cnt == st.ocr); // [RULE13] [RULE18]
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= {OCR_RESET, OCR_RESET};
      end else begin
         st <= next_st;
      end
   end

   assign buf_val = st.buffer;
   assign ocr_val = st.ocr;
endmodule // tmr8_cmp

// >>> dv/tmr8_props.sv
// concurrent checks on the timer/counter top ports
module tmr8_props
   import tmr8_pkg::*;
(
   // clock and reset
   input wire logic MCLK,
   input wire logic RST_N,
   // controls
   input wire logic [2:0] CLOCK_SELECT_FIELD,
   input wire logic WAVE_MODE_BIT0,
   input wire logic WAVE_MODE_BIT1,
   input wire logic WAVE_MODE_BIT2,
   input wire logic COUNT_WRITE,
   input wire logic [CNT_W-1:0] COUNT_WDATA,
   input wire logic COMPARE_A_WRITE,
   input wire logic [CNT_W-1:0] COMPARE_A_WDATA,
   input wire logic [N_FLAGS-1:0] MASK_REGISTER,
   input wire logic [N_FLAGS-1:0] FLAG_CLEAR,
   // results
   input wire logic [CNT_W-1:0] COUNT_VALUE,
   input wire logic [CNT_W-1:0] COMPARE_VALUE_A,
   input wire logic [N_FLAGS-1:0] FLAG_REGISTER,
   input wire logic [N_FLAGS-1:0] INT_REQUEST
);
   logic [2:0] mode;
   logic run;
   assign mode = {WAVE_MODE_BIT2, WAVE_MODE_BIT1, WAVE_MODE_BIT0};
   assign run = (CLOCK_SELECT_FIELD == CS_SYS) && !COUNT_WRITE;
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   a_write_wins: assert property (COUNT_WRITE |=> COUNT_VALUE == $past(COUNT_WDATA))
      else $error("count write not taken");
   a_stop_holds: assert property (CLOCK_SELECT_FIELD == CS_STOP && !COUNT_WRITE |=>
      $stable(COUNT_VALUE))
      else $error("count moved while stopped");
   a_step_one: assert property (run && mode == WGM_NORMAL |=>
      COUNT_VALUE == $past(COUNT_VALUE) + CNT_STEP)
      else $error("count step wrong");
   a_ovf_wrap: assert property (run && mode == WGM_NORMAL &&
      COUNT_VALUE == CNT_MAX |=> FLAG_REGISTER[FLG_OVF] && COUNT_VALUE == CNT_BOTTOM)
      else $error("wrap or overflow wrong");
   a_ctc_top: assert property (run && mode == WGM_CTC && !$past(COUNT_WRITE) &&
      !COMPARE_A_WRITE && COUNT_VALUE == COMPARE_VALUE_A |=> COUNT_VALUE == CNT_BOTTOM)
      else $error("clear at top missing");
   a_match_a: assert property (run && mode == WGM_NORMAL && !$past(COUNT_WRITE) &&
      !COMPARE_A_WRITE && COUNT_VALUE == COMPARE_VALUE_A |=> FLAG_REGISTER[FLG_MA])
      else $error("match flag missing");
   a_flag_clear: assert property (FLAG_CLEAR[FLG_OVF] &&
      CLOCK_SELECT_FIELD == CS_STOP |=> !FLAG_REGISTER[FLG_OVF])
      else $error("flag not cleared");
   a_flag_sticky: assert property (FLAG_REGISTER[FLG_MA] && !FLAG_CLEAR[FLG_MA] |=>
      FLAG_REGISTER[FLG_MA])
      else $error("flag dropped");
   a_int_mask: assert property (1'b1 |=>
      INT_REQUEST == ($past(FLAG_REGISTER) & $past(MASK_REGISTER)))
      else $error("request mask wrong");
   a_cmp_back: assert property (COMPARE_A_WRITE |=>
      COMPARE_VALUE_A == $past(COMPARE_A_WDATA))
      else $error("compare readback wrong");
endmodule // tmr8_props

bind tmr8_top tmr8_props u_props (.MCLK, .RST_N, .CLOCK_SELECT_FIELD, .WAVE_MODE_BIT0,
   .WAVE_MODE_BIT1, .WAVE_MODE_BIT2, .COUNT_WRITE, .COUNT_WDATA, .COMPARE_A_WRITE,
   .COMPARE_A_WDATA, .MASK_REGISTER, .FLAG_CLEAR, .COUNT_VALUE, .COMPARE_VALUE_A,
   .FLAG_REGISTER, .INT_REQUEST);

// >>> dv/tmr8_top_tb.sv
// self-checking bench of the 8-bit timer/counter
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module tmr8_top_tb
   import tmr8_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic ext = 1'b0;
   logic [3:0] tap = 4'h0;
   logic [2:0] cs = 3'h0;
   logic [2:0] wm = 3'h0;
   logic [1:0] oma = 2'h0;
   logic [1:0] omb = 2'h0;
   logic fma = 1'b0;
   logic fmb = 1'b0;
   logic cw = 1'b0;
   logic aw = 1'b0;
   logic bw = 1'b0;
   logic [7:0] cd = 8'h00;
   logic [7:0] ad = 8'h00;
   logic [7:0] bd = 8'h00;
   logic [2:0] msk = 3'h0;
   logic [2:0] fcl = 3'h0;
   logic [7:0] cnt, ca, cb, v;
   logic [2:0] flg, irq;
   logic pa, pb;
   logic [7:0] ph [4] = '{8'hfe, 8'hff, 8'hfe, 8'hfd};
   int fail_count = 0;
   int compares = 0;
   int i;

   always #5 mclk = ~mclk;

   tmr8_top dut (
      .MCLK(mclk), .RST_N(rst_n), .EXT_COUNT_INPUT(ext), .PRESCALE_TAP(tap),
      .CLOCK_SELECT_FIELD(cs), .WAVE_MODE_BIT0(wm[0]), .WAVE_MODE_BIT1(wm[1]),
      .WAVE_MODE_BIT2(wm[2]), .OUTPUT_MODE_A(oma), .OUTPUT_MODE_B(omb),
      .FORCE_MATCH_A(fma), .FORCE_MATCH_B(fmb), .COUNT_WRITE(cw), .COUNT_WDATA(cd),
      .COMPARE_A_WRITE(aw), .COMPARE_A_WDATA(ad), .COMPARE_B_WRITE(bw),
      .COMPARE_B_WDATA(bd), .MASK_REGISTER(msk), .FLAG_CLEAR(fcl), .COUNT_VALUE(cnt),
      .COMPARE_VALUE_A(ca), .COMPARE_VALUE_B(cb), .FLAG_REGISTER(flg),
      .INT_REQUEST(irq), .COMPARE_PIN_A(pa), .COMPARE_PIN_B(pb));

   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic wr_cnt(input logic [7:0] d);
      cw = 1'b1;
      cd = d;
      step(1);
      cw = 1'b0;
   endtask

   task automatic wr_cmp(input logic [7:0] a, input logic [7:0] b);
      aw = 1'b1;
      bw = 1'b1;
      ad = a;
      bd = b;
      step(1);
      aw = 1'b0;
      bw = 1'b0;
   endtask

   task automatic final_report();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic wait_cnt(input logic [7:0] e);
      for (int k = 0; k < 40 && cnt !== e; k++) begin
         step(1);
      end
      if (cnt !== e) begin
         fail_count++;
         $display("[FAIL] t=%0t got %h exp %h", $time, cnt, e);
         final_report();
      end
   endtask

   initial begin
      step(4);
      rst_n = 1'b1;
      step(2);
      `CHK({cnt, ca, cb, flg, irq, pa, pb}, 32'h0)
      $display("test reset done");
      wr_cnt(8'h5a);
      wr_cmp(8'h3c, 8'hc3);
      step(5);
      `CHK({cnt, ca, cb}, 24'h5a3cc3)
      $display("test stop done");
      msk = 3'h7;
      wr_cnt(8'hfe);
      cs = CS_SYS;
      step(1);
      `CHK(cnt, 8'hff)
      step(1);
      `CHK({cnt, flg[FLG_OVF]}, 9'h001)
      step(1);
      `CHK(irq[FLG_OVF], 1'b1)
      wr_cnt(8'h10);
      `CHK(cnt, 8'h10)
      cs = CS_STOP;
      fcl = 3'h7;
      step(1);
      fcl = 3'h0;
      `CHK(flg, 3'h0)
      $display("test wrap done");
      msk = 3'h2;
      wr_cmp(8'h20, 8'h22);
      wr_cnt(8'h1e);
      cs = CS_SYS;
      step(3);
      `CHK({cnt, flg}, 11'h10a)
      step(1);
      `CHK(irq, 3'h2)
      step(1);
      `CHK(flg, 3'h6)
      cs = CS_STOP;
      fcl = 3'h7;
      step(1);
      fcl = 3'h0;
      wr_cnt(8'h20);
      cs = CS_SYS;
      step(2);
      cs = CS_STOP;
      `CHK(flg[FLG_MA], 1'b0)
      $display("test match done");
      wm = WGM_CTC;
      wr_cmp(8'h05, 8'h22);
      wr_cnt(8'h00);
      cs = CS_SYS;
      for (i = 1; i < 9; i++) begin
         step(1);
         v = 8'(i % 6);
         `CHK(cnt, v)
      end
      cs = CS_STOP;
      `CHK(flg[FLG_OVF], 1'b0)
      $display("test ctc done");
      wm = WGM_FAST_MAX;
      oma = COM_CLEAR;
      wr_cmp(8'h10, 8'h22);
      wr_cnt(8'hfe);
      cs = CS_SYS;
      wait_cnt(8'h02);
      `CHK({pa, flg[FLG_OVF]}, 2'h3)
      wr_cmp(8'h30, 8'h22);
      wait_cnt(8'h14);
      `CHK({pa, ca}, 9'h030)
      cs = CS_STOP;
      $display("test fast done");
      wm = WGM_PHASE_MAX;
      wr_cnt(8'hfd);
      cs = CS_SYS;
      for (i = 0; i < 4; i++) begin
         step(1);
         `CHK(cnt, ph[i])
      end
      cs = CS_STOP;
      $display("test phase done");
      wm = WGM_NORMAL;
      oma = COM_TOGGLE;
      fcl = 3'h7;
      step(1);
      fcl = 3'h0;
      fma = 1'b1;
      step(1);
      fma = 1'b0;
      step(1);
      `CHK({pa, flg}, 4'h8)
      $display("test force done");
      wr_cmp(8'h3c, 8'h22);
      wr_cnt(8'h00);
      cs = CS_EXT_RISE;
      ext = 1'b1;
      wait_cnt(8'h01);
      step(6);
      `CHK(cnt, 8'h01)
      cs = CS_EXT_FALL;
      step(6);
      ext = 1'b0;
      wait_cnt(8'h02);
      ext = 1'b1;
      step(6);
      `CHK(cnt, 8'h02)
      for (i = 0; i < 4; i++) begin
         cs = CS_TAP_BASE + 3'(i);
         tap = 4'h1 << i;
         step(1);
         tap = 4'h1 << ((i + 1) % 4);
         step(1);
         tap = 4'h0;
         step(1);
         v = 8'(i + 3);
         `CHK(cnt, v)
      end
      cs = CS_STOP;
      $display("test sources done");
      wr_cmp(8'h06, 8'h03);
      wr_cnt(8'h00);
      wm = WGM_FAST_OCR;
      omb = COM_SET;
      cs = CS_SYS;
      step(4);
      `CHK({cnt, pa, pb, flg}, 13'h009c)
      step(3);
      `CHK({cnt, pa, pb, flg}, 13'h0007)
      $display("test fast top done");
      wm = WGM_PHASE_OCR;
      omb = COM_CLEAR;
      fcl = 3'h7;
      step(1);
      fcl = 3'h0;
      step(6);
      `CHK({cnt, pa, pb}, 10'h016)
      step(3);
      `CHK({cnt, pb, flg}, 12'h02f)
      cs = CS_STOP;
      wm = WGM_NORMAL;
      omb = COM_TOGGLE;
      fmb = 1'b1;
      step(1);
      fmb = 1'b0;
      step(1);
      `CHK({pa, pb}, 2'h2)
      $display("test phase top done");
      final_report();
   end
endmodule // tmr8_top_tb
